// ### shared/fpc_defs.svh
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

`define FPC_CMD_READ 8'h00
`define FPC_CMD_PROG 8'h40
`define FPC_CMD_ERASE 8'h20
`define FPC_CMD_STAT 8'h71
`define FPC_PAGE_BYTES 8'h80
`define FPC_PAGE_LAST 7'h7F
`define FPC_ST_END 7
`define FPC_ST_CMDERR 6
`define FPC_ST_PRGERR 5
`define FPC_ST_ERSERR 4
`define FPC_ST_RETRY 1
`define FPC_ST_ADRERR 0
`define FPC_ST_RESET 8'h00
`define FPC_NXTC_US 20
`define FPC_CLK_MHZ 10
`define FPC_NXTC_CYC (`FPC_NXTC_US * `FPC_CLK_MHZ)
`define FPC_ADDR_W 18
`define FPC_ADDR_MAX 18'h3FFFF
`define FPC_BUSY_CYC 16'h0100
`define FPC_CNT_ONE 16'h0001
`define FPC_CNT_ZERO 16'h0000
`define FPC_RETRY_MAX 4'h3
`define FPC_REG_STAT 12'h000
`define FPC_REG_MASK 12'h004
`define FPC_REG_LIVE 12'h008

`endif

// ### shared/fpc_pkg.sv
package fpc_pkg;
    typedef enum logic [2:0] {
        FPC_IDLE = 3'b000,
        FPC_ERASE2 = 3'b001,
        FPC_STAT2 = 3'b010,
        FPC_PAGE = 3'b011,
        FPC_BUSY = 3'b100,
        FPC_READ = 3'b101,
        FPC_STATRD = 3'b110
    } fpc_state_e;
    typedef enum logic [1:0] {
        FPC_OP_NONE = 2'b00,
        FPC_OP_PROG = 2'b01,
        FPC_OP_ERASE = 2'b10
    } fpc_op_e;
endpackage

// ### hdl/fpc_wr_strobe.sv
`timescale 1ns/1ps
`default_nettype none
// Turns the write-enable pulse into a one-cycle write event at its rising edge
module fpc_wr_strobe (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic [7:0] din,
    input wire logic [17:0] ain,
    output logic wr_evt,
    output logic [7:0] wr_data,
    output logic [17:0] wr_addr
);
    logic we_q;
    logic next_we_q;
    logic [7:0] next_wr_data;
    logic [17:0] next_wr_addr;
    logic next_wr_evt;
    always_comb begin
        next_we_q = we_n | ce_n;
        next_wr_evt = ~we_q & next_we_q & ~ce_n;
        next_wr_data = next_wr_evt ? din : wr_data;
        next_wr_addr = next_wr_evt ? ain : wr_addr;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            we_q <= 1'b1;
            wr_evt <= 1'b0;
            wr_data <= 8'h00;
            wr_addr <= 18'h00000;
        end else begin
            we_q <= next_we_q;
            wr_evt <= next_wr_evt;
            wr_data <= next_wr_data;
            wr_addr <= next_wr_addr;
        end
    end
endmodule
`default_nettype wire

// ### hdl/fpc_apb_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.svh"
// APB slave: 0x0 status (W1C), 0x4 mask, 0x8 live status byte
module fpc_apb_irq (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] evt,
    input wire logic [7:0] live_status,
    output logic irq
);
    logic [2:0] sticky;
    logic [2:0] mask;
    logic [2:0] next_sticky;
    logic [2:0] next_mask;
    logic [31:0] next_prdata;
    logic acc;
    logic hit;
    always_comb begin
        acc = psel & penable;
        hit = (paddr == `FPC_REG_STAT) | (paddr == `FPC_REG_MASK) | (paddr == `FPC_REG_LIVE);
        next_mask = mask;
        next_sticky = sticky;
        next_prdata = prdata;
        if (acc & pwrite & (paddr == `FPC_REG_MASK)) begin
            next_mask = pwdata[2:0];
        end
        if (acc & pwrite & (paddr == `FPC_REG_STAT)) begin
            next_sticky = sticky & ~pwdata[2:0];
        end
        next_sticky = next_sticky | evt;
        // Read data latched in the setup cycle, stands through the access
        if (psel & ~penable) begin
            unique case (paddr)
                `FPC_REG_STAT: next_prdata = {29'h0, sticky};
                `FPC_REG_MASK: next_prdata = {29'h0, mask};
                `FPC_REG_LIVE: next_prdata = {24'h0, live_status};
                default: next_prdata = 32'h00000000;
            endcase
        end
        pready = 1'b1;
        pslverr = acc & ~hit;
        irq = |(sticky & mask);
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sticky <= 3'h0;
            mask <= 3'h0;
            prdata <= 32'h00000000;
        end else begin
            sticky <= next_sticky;
            mask <= next_mask;
            prdata <= next_prdata;
        end
    end
endmodule
`default_nettype wire

// ### hdl/fpc_cmd_port.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.svh"
// Function
// - Program: code 40, then 128 address and data writes, 129 cycles.
// - Erase: two consecutive writes of code 20, then erasing starts.
// - Status read: two consecutive writes of code 71, then status byte output.
// - Memory read: write code 00, then reads return array data.
// - Status bit 7 is 0 on normal end, 1 on abnormal end.
// - Status bit 6 is 1 after a command error.
// - Status bit 5 flags program error, bit 4 erase error.
// - Status bit 1 flags retry overflow, bit 0 address error.
// - Status bits 3 and 2 undefined; programmer ignores them.
// - Status byte is all zero before any result.
// - While busy, data bit 7 polls busy or complete; here it is 0 while busy, then shows status bit 7, which is 0 on a normal end.
// - While busy, data bit 6 polls normal or abnormal end; here it is 1 once an attempt has failed, then shows status bit 6.
module fpc_cmd_port
    import fpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [17:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic mem_we,
    output logic [17:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic mem_erase,
    input wire logic mem_fail,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    logic wr_evt;
    logic [7:0] wr_data;
    logic [17:0] wr_addr;
    fpc_state_e state;
    fpc_state_e next_state;
    fpc_op_e op;
    fpc_op_e next_op;
    logic [7:0] status;
    logic [7:0] next_status;
    logic [6:0] idx;
    logic [6:0] next_idx;
    logic [7:0] page [0:127];
    logic [17:0] base;
    logic [17:0] next_base;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [3:0] retry;
    logic [3:0] next_retry;
    logic [7:0] next_data_out;
    logic done_evt;
    logic next_done_evt;
    logic cmderr_evt;
    logic next_cmderr_evt;
    logic [2:0] evt;

    function automatic logic is_code(input logic [7:0] d, input logic [7:0] code);
        is_code = (d == code);
    endfunction

    fpc_wr_strobe u_strobe (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce_n(ce_n),
        .we_n(we_n),
        .din(data_in),
        .ain(addr),
        .wr_evt(wr_evt),
        .wr_data(wr_data),
        .wr_addr(wr_addr)
    );

    always_ff @(posedge sys_clk) begin
        if (wr_evt && state == FPC_PAGE) begin
            page[wr_addr[6:0]] <= wr_data;
        end
    end

    always_comb begin
        next_state = state;
        next_op = op;
        next_status = status;
        next_idx = idx;
        next_base = base;
        next_cnt = cnt;
        next_retry = retry;
        next_done_evt = 1'b0;
        next_cmderr_evt = 1'b0;
        mem_we = 1'b0;
        mem_erase = 1'b0;
        mem_addr = base | {11'h000, idx};
        mem_wdata = page[idx];
        // Read mode addresses the array straight from the pins
        if (state == FPC_READ) begin
            mem_addr = addr;
        end
        unique case (state)
            FPC_IDLE, FPC_READ, FPC_STATRD: begin
                if (wr_evt) begin
                    if (is_code(wr_data, `FPC_CMD_READ)) begin
                        next_state = FPC_READ;
                    end else if (is_code(wr_data, `FPC_CMD_PROG)) begin
                        next_state = FPC_PAGE;
                        next_idx = 7'h00;
                        next_status = `FPC_ST_RESET;
                    end else if (is_code(wr_data, `FPC_CMD_ERASE)) begin
                        next_state = FPC_ERASE2;
                    end else if (is_code(wr_data, `FPC_CMD_STAT)) begin
                        next_state = FPC_STAT2;
                    end else begin
                        next_state = FPC_IDLE;
                        next_status = `FPC_ST_RESET;
                        next_status[`FPC_ST_CMDERR] = 1'b1;
                        next_status[`FPC_ST_END] = 1'b1;
                        next_cmderr_evt = 1'b1;
                    end
                end
            end
            FPC_ERASE2, FPC_STAT2: begin
                if (wr_evt) begin
                    if (state == FPC_ERASE2 && is_code(wr_data, `FPC_CMD_ERASE)) begin
                        next_state = FPC_BUSY;
                        next_op = FPC_OP_ERASE;
                        next_cnt = `FPC_BUSY_CYC;
                        next_retry = 4'h0;
                        next_status = `FPC_ST_RESET;
                    end else if (state == FPC_STAT2 && is_code(wr_data, `FPC_CMD_STAT)) begin
                        next_state = FPC_STATRD;
                    end else begin
                        next_state = FPC_IDLE;
                        next_status = `FPC_ST_RESET;
                        next_status[`FPC_ST_CMDERR] = 1'b1;
                        next_status[`FPC_ST_END] = 1'b1;
                        next_cmderr_evt = 1'b1;
                    end
                end
            end
            FPC_PAGE: begin
                if (wr_evt) begin
                    if (idx == 7'h00) begin
                        next_base = wr_addr & ~{11'h000, `FPC_PAGE_LAST};
                    end else if ((wr_addr & ~{11'h000, `FPC_PAGE_LAST}) != base) begin
                        // Byte outside the page opened by the first byte
                        next_status[`FPC_ST_ADRERR] = 1'b1;
                    end
                    next_idx = idx + 7'h01;
                    if (idx == `FPC_PAGE_LAST) begin
                        next_state = FPC_BUSY;
                        next_op = FPC_OP_PROG;
                        next_idx = 7'h00;
                        next_cnt = `FPC_BUSY_CYC;
                        next_retry = 4'h0;
                    end
                end
            end
            FPC_BUSY: begin
                if (op == FPC_OP_PROG) begin
                    mem_we = 1'b1;
                end else begin
                    mem_erase = 1'b1;
                end
                next_idx = idx + 7'h01;
                next_cnt = cnt - `FPC_CNT_ONE;
                if (mem_fail) begin
                    next_retry = retry + 4'h1;
                    next_cnt = `FPC_BUSY_CYC;
                end
                if (cnt == `FPC_CNT_ONE || retry == `FPC_RETRY_MAX || status[`FPC_ST_ADRERR]) begin
                    next_state = FPC_STATRD;
                    next_done_evt = 1'b1;
                    if (retry == `FPC_RETRY_MAX) begin
                        next_status[`FPC_ST_RETRY] = 1'b1;
                        if (op == FPC_OP_PROG) begin
                            next_status[`FPC_ST_PRGERR] = 1'b1;
                        end else begin
                            next_status[`FPC_ST_ERSERR] = 1'b1;
                        end
                    end
                    next_status[`FPC_ST_END] = (retry == `FPC_RETRY_MAX)
                        | status[`FPC_ST_ADRERR];
                end
            end
            default: next_state = FPC_IDLE;
        endcase
        // Polling bits while busy: 7 low until done, 6 shows failure so far
        if (state == FPC_BUSY) begin
            next_data_out = {1'b0, (retry != 4'h0), 6'h00};
        end else if (state == FPC_READ) begin
            next_data_out = mem_rdata;
        end else begin
            next_data_out = status & 8'hF3;
        end
        data_oe = ~ce_n & ~oe_n & we_n;
        evt = {cmderr_evt, done_evt & status[`FPC_ST_END], done_evt};
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= FPC_IDLE;
            op <= FPC_OP_NONE;
            status <= `FPC_ST_RESET;
            idx <= 7'h00;
            base <= 18'h00000;
            cnt <= `FPC_CNT_ZERO;
            retry <= 4'h0;
            data_out <= 8'h00;
            done_evt <= 1'b0;
            cmderr_evt <= 1'b0;
        end else begin
            state <= next_state;
            op <= next_op;
            status <= next_status;
            idx <= next_idx;
            base <= next_base;
            cnt <= next_cnt;
            retry <= next_retry;
            data_out <= next_data_out;
            done_evt <= next_done_evt;
            cmderr_evt <= next_cmderr_evt;
        end
    end

    fpc_apb_irq u_apb (
        .sys_clk(sys_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .evt(evt),
        .live_status(status),
        .irq(irq)
    );

    sequence erase_pair_s;
        wr_evt && state == FPC_ERASE2 && wr_data == `FPC_CMD_ERASE;
    endsequence
    sequence enter_busy_s;
        state == FPC_BUSY && op == FPC_OP_ERASE;
    endsequence

    erase_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        erase_pair_s |=> enter_busy_s)
        else $error("erase did not start after two codes");
    stat_enter_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_evt && state == FPC_STAT2 && wr_data == `FPC_CMD_STAT |=> state == FPC_STATRD)
        else $error("status read not entered");
    read_enter_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_evt && state == FPC_IDLE && wr_data == `FPC_CMD_READ |=> state == FPC_READ)
        else $error("memory read not entered");
    page_full_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_evt && state == FPC_PAGE && idx == `FPC_PAGE_LAST |=> state == FPC_BUSY)
        else $error("page did not close at 128 bytes");
    end_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        done_evt |-> status[`FPC_ST_END] == (status[`FPC_ST_RETRY] | status[`FPC_ST_ADRERR]))
        else $error("end flag wrong");
    cmd_error_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(cmderr_evt) |-> status[`FPC_ST_CMDERR] && status[`FPC_ST_END])
        else $error("command error not flagged");
    retry_err_a: assert property (@(posedge sys_clk) disable iff (rst)
        status[`FPC_ST_RETRY] && state != FPC_BUSY |->
        (status[`FPC_ST_PRGERR] | status[`FPC_ST_ERSERR]))
        else $error("retry without error cause");
    undef_bits_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(state) != FPC_READ |-> data_out[3:2] == 2'b00)
        else $error("undefined bits driven");
    poll_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(state) == FPC_BUSY && state == FPC_BUSY |-> !data_out[7])
        else $error("poll bit high while busy");
    retry_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == FPC_BUSY |-> retry <= `FPC_RETRY_MAX)
        else $error("retry count overran");
endmodule
`default_nettype wire

// ### test/fpc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Flash array behind the command port, erased cells read FF
module fpc_mem_model (
    input wire logic sys_clk,
    input wire logic mem_we,
    input wire logic [17:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic mem_erase,
    output logic mem_fail,
    input wire logic fail_en
);
    logic [7:0] arr [0:1023];
    logic [5:0] cnt;
    initial begin
        cnt = 6'h00;
        for (int i = 0; i < 1024; i++) arr[i] = 8'hFF;
    end
    assign mem_rdata = arr[mem_addr[9:0]];
    // One failed attempt every 64 busy cycles while asked for
    assign mem_fail = fail_en && (mem_we || mem_erase) && cnt == 6'h3F;
    always @(posedge sys_clk) begin
        cnt <= (mem_we || mem_erase) ? cnt + 6'h01 : 6'h00;
        if (mem_erase) begin
            for (int i = 0; i < 1024; i++) arr[i] <= 8'hFF;
        end else if (mem_we) begin
            arr[mem_addr[9:0]] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk, rst, ce_n, we_n, oe_n, psel, penable, pwrite, fail_en, smp;
    logic [17:0] addr, mem_addr;
    logic [7:0] data_in, data_out, mem_wdata, mem_rdata;
    logic [7:0] pg [0:127];
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rdq;
    logic data_oe, mem_we, mem_erase, mem_fail, pready, pslverr, irq, errq;
    logic [15:0] expq [$];
    int n_errors = 0;
    int num_checks = 0;

    fpc_cmd_port dut (.sys_clk(sys_clk), .rst(rst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_erase(mem_erase), .mem_fail(mem_fail), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    fpc_mem_model mem (.sys_clk(sys_clk), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_erase(mem_erase),
        .mem_fail(mem_fail), .fail_en(fail_en));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] m);
        num_checks++;
        if ((seen & m) !== (exp & m)) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Programmer write cycle, then the requested idle gap
    task automatic pwr(input logic [17:0] a, input logic [7:0] d, input int gap);
        @(posedge sys_clk);
        ce_n <= 1'b0;
        we_n <= 1'b0;
        addr <= a;
        data_in <= d;
        @(posedge sys_clk);
        we_n <= 1'b1;
        @(posedge sys_clk);
        ce_n <= 1'b1;
        repeat (gap) @(posedge sys_clk);
    endtask

    // Programmer read cycle; expectation noted with a care mask
    task automatic prd(input logic [17:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge sys_clk);
        ce_n <= 1'b0;
        oe_n <= 1'b0;
        addr <= a;
        expq.push_back({m, e});
        repeat (3) @(posedge sys_clk);
        smp <= 1'b1;
        @(posedge sys_clk);
        smp <= 1'b0;
        ce_n <= 1'b1;
        oe_n <= 1'b1;
    endtask

    always @(posedge sys_clk) begin
        if (psel && penable && pready) begin
            rdq <= prdata;
            errq <= pslverr;
        end
        if (smp) begin
            check(32'(data_oe), 32'h1, 32'h1);
            check(32'(data_out), 32'(expq[0][7:0]), 32'(expq[0][15:8]));
            void'(expq.pop_front());
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge sys_clk);
        rd = rdq;
    endtask

    task automatic wait_done();
        rd = 32'h0;
        for (int i = 0; i < 3000 && rd[1:0] === 2'b00; i++) apb(1'b0, 12'h000, 32'h0);
        check(32'(|rd[1:0]), 32'h1, 32'h1);
    endtask

    task automatic program_page(input logic [17:0] base);
        pwr(18'h0, 8'h40, 200);
        for (int i = 0; i < 128; i++) begin
            pg[i] = 8'($urandom);
            pwr(base + 18'(i), pg[i], 2);
        end
    endtask

    initial begin
        {ce_n, we_n, oe_n, psel, penable, pwrite, fail_en, smp} = 8'hE0;
        {rst, addr, data_in, paddr, pwdata} = {1'b1, 18'h0, 8'h00, 12'h000, 32'h0};
        void'($urandom(65));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        prd(18'h0, 8'h00, 8'hF3);
        pwr(18'h0, 8'h71, 200);
        pwr(18'h0, 8'h71, 200);
        prd(18'h0, 8'h00, 8'hF3);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0, 32'hF3);
        $display("test reset status done");
        apb(1'b1, 12'h004, 32'h1);
        program_page(18'h100);
        prd(18'h0, 8'h00, 8'hC0);
        wait_done();
        check(rd, 32'h1, 32'h3);
        check(32'(irq), 32'h1, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        check(32'(irq), 32'h0, 32'h1);
        apb(1'b1, 12'h000, 32'h7);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0, 32'h7);
        prd(18'h0, 8'h00, 8'hF3);
        pwr(18'h0, 8'h00, 200);
        for (int i = 0; i < 128; i++) prd(18'h100 + 18'(i), pg[i], 8'hFF);
        $display("test program and read done");
        fail_en <= 1'b1;
        pwr(18'h0, 8'h20, 200);
        pwr(18'h0, 8'h20, 100);
        prd(18'h0, 8'h40, 8'hC0);
        wait_done();
        fail_en <= 1'b0;
        check(rd, 32'h2, 32'h2);
        prd(18'h0, 8'h92, 8'hF3);
        apb(1'b1, 12'h000, 32'h7);
        $display("test erase failure done");
        fail_en <= 1'b1;
        program_page(18'h200);
        wait_done();
        fail_en <= 1'b0;
        prd(18'h0, 8'hA2, 8'hF3);
        apb(1'b1, 12'h000, 32'h7);
        $display("test program failure done");
        pwr(18'h0, 8'h40, 200);
        for (int i = 0; i < 128; i++) begin
            pwr(18'h300 + 18'(i) + ((i == 9) ? 18'h080 : 18'h000), 8'h5A, 2);
        end
        wait_done();
        check(rd, 32'h2, 32'h2);
        prd(18'h0, 8'h81, 8'hF3);
        apb(1'b1, 12'h000, 32'h7);
        $display("test address error done");
        pwr(18'h0, 8'h55, 200);
        prd(18'h0, 8'hC0, 8'hF3);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h4, 32'h4);
        apb(1'b0, 12'h00C, 32'h0);
        check({31'h0, errq}, 32'h1, 32'h1);
        check(rd, 32'h0, 32'hFFFFFFFF);
        $display("test command error done");
        give_verdict();
    end

    initial begin
        #8000000;
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
